// >>> rtl/tmw8_pkg.sv
// package for the 8-bit waveform timer: modes, actions, control field positions, register map
// assumes a single 25 MHz clock domain; registers sit behind a plain strobe port
package tmw8_pkg;
  localparam int TMW8_CLK_HZ = 25_000_000;
  localparam logic [7:0] TMW8_MAX = 8'h00_FF;
  localparam logic [7:0] TMW8_BOTTOM = 8'h00_00;
  // counting modes
  localparam logic [1:0] TMW8_WM_NORMAL = 2'h0;
  localparam logic [1:0] TMW8_WM_PCPWM = 2'h1;
  localparam logic [1:0] TMW8_WM_CTC = 2'h2;
  localparam logic [1:0] TMW8_WM_FAST = 2'h3;
  // output actions
  localparam logic [1:0] TMW8_OA_NONE = 2'h0;
  localparam logic [1:0] TMW8_OA_TOGGLE = 2'h1;
  localparam logic [1:0] TMW8_OA_CLEAR = 2'h2;
  localparam logic [1:0] TMW8_OA_SET = 2'h3;
  // register offsets
  localparam logic [3:0] TMW8_REG_CTRL = 4'h0;
  localparam logic [3:0] TMW8_REG_COUNT = 4'h1;
  localparam logic [3:0] TMW8_REG_CMP = 4'h2;
  localparam logic [3:0] TMW8_REG_FLAGS = 4'h3;
  // control field positions
  localparam int TMW8_CTRL_CS_LSB = 0;
  localparam int TMW8_CTRL_WM_LSB = 3;
  localparam int TMW8_CTRL_OA_LSB = 5;
  localparam int TMW8_CTRL_DIR = 7;
  // flag bit positions
  localparam int TMW8_FLG_OVF = 0;
  localparam int TMW8_FLG_CMP = 1;
  localparam logic [7:0] TMW8_CTRL_RST = 8'h00_00;
  localparam logic [7:0] TMW8_CMP_RST = 8'h00_00;
  localparam logic [7:0] TMW8_READ_NONE = 8'h00_00;
endpackage

// >>> rtl/tmw8_timer.sv
// 8-bit timer with one compare channel and a waveform output pin
// assumes i_ref_clk at 25 MHz, software on a plain strobe port, pin direction from software
// Summary of operation
// - normal mode counts up always, wraps from 0xFF to 0x00.
// - normal mode sets overflow flag when count becomes zero.
// - normal mode accepts counter writes any time.
// - mode 2 clears counter on compare match; compare is top.
// - mode 2 unbuffered compare; missed match runs to 0xFF then wraps.
// - mode 2 action 1 toggles output on every match.
// - mode 2 sets overflow flag on passing max to zero.
// - mode 3 counts up to max and clears next tick, 256 period.
// - mode 3 action 2 clear on match set at bottom; action 3 inverse.
// - mode 3 sets overflow flag when counter reaches max.
// - mode 3 compare zero gives spike; compare max gives constant level.
// - mode 3 action 1 toggles on match; compare stays buffered.
// - mode 1 counts up to max and back down, period 510.
// - mode 1 reverses at max, holding max one tick.
// - mode 1 action 2 clears on up match, sets on down; 3 inverse.
// - mode 1 sets overflow flag when counter reaches zero.
// - mode 1 compare zero holds low, max holds high; inverted opposite.
// - mode 1 makes symmetry transition at bottom without match when needed.
// - counting depends only on mode bits, never on output action bits.
// - waveform reaches pin only when direction control says output.
// - timer tick is clock divided by 1,8,32,64,128,256 or 1024.
// - compare flag set one clock after the matching tick; software clears by writing one.
// - pwm modes write compare buffer; other modes write compare directly.
// - action zero leaves output alone; counter write overrides count or clear.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
module tmw8_timer
  import tmw8_pkg::*;
#(
  parameter int PRESCALE_W = 10
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // waveform pin
  output logic o_wave_output,
  output logic o_wave_output_oe,
  // flags as levels
  output logic o_overflow_flag,
  output logic o_compare_match_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_q;
  logic [7:0] count_value_q;
  logic [7:0] compare_value_q;
  logic [7:0] cmp_buf_q;
  logic [7:0] rdata_q;
  logic wave_q;
  logic down_q;
  logic ovf_q;
  logic cmpf_q;
  logic match_q;
  logic block_q;
  logic [PRESCALE_W-1:0] pre_q;

  logic [2:0] clk_sel;
  logic [1:0] wave_mode_select;
  logic [1:0] output_action_select;
  logic is_pwm;
  logic tick;
  logic match;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_flg;
  logic [7:0] cnt_d;
  logic down_d;
  logic wave_d;
  logic ovf_set;
  logic cnt_at_max;
  logic cnt_at_bottom;
  logic load_pc;
  logic load_fast;

  assign clk_sel = ctrl_q[TMW8_CTRL_CS_LSB +: 3];
  assign wave_mode_select = ctrl_q[TMW8_CTRL_WM_LSB +: 2];
  assign output_action_select = ctrl_q[TMW8_CTRL_OA_LSB +: 2];
  assign is_pwm = wave_mode_select[0];
  assign wr_ctrl = i_wr && (i_addr == TMW8_REG_CTRL);
  assign wr_cnt = i_wr && (i_addr == TMW8_REG_COUNT);
  assign wr_cmp = i_wr && (i_addr == TMW8_REG_CMP);
  assign wr_flg = i_wr && (i_addr == TMW8_REG_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // extreme-value decode, shared by compare-buffer load and waveform logic
  function automatic logic at_max(input logic [7:0] v);
    return v == TMW8_MAX;
  endfunction

  function automatic logic at_bottom(input logic [7:0] v);
    return v == TMW8_BOTTOM;
  endfunction

  assign cnt_at_max = at_max(count_value_q);
  assign cnt_at_bottom = at_bottom(count_value_q);

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: tick is a clock enable, timer stops when select is zero
  // restarts from zero when stopped, so the first tick after start is a full period
  function automatic logic tap_hit(input logic [2:0] sel, input logic [PRESCALE_W-1:0] p);
    logic hit;
    hit = 1'b0;
    case (sel)
      3'h1: hit = 1'b1;
      3'h2: hit = (p[2:0] == 3'h7);
      3'h3: hit = (p[4:0] == 5'h1F);
      3'h4: hit = (p[5:0] == 6'h3F);
      3'h5: hit = (p[6:0] == 7'h7F);
      3'h6: hit = (p[7:0] == 8'hFF);
      3'h7: hit = (p[9:0] == 10'h3FF);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= '0;
    end else if (clk_sel == 3'h0) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end
  assign tick = tap_hit(clk_sel, pre_q);

  ////////////////////////////////////////////////////////////////////////////
  // counter sequence, selected by mode bits only
  assign match = (count_value_q == compare_value_q) && !block_q;

  always_comb begin
    cnt_d = count_value_q;
    down_d = down_q;
    ovf_set = 1'b0;
    case (wave_mode_select)
      TMW8_WM_NORMAL: begin
        cnt_d = count_value_q + 8'h01;
        ovf_set = (count_value_q == TMW8_MAX);
        down_d = 1'b0;
      end
      TMW8_WM_CTC: begin
        // compare written below count misses; runs on to max and wraps
        if (count_value_q == compare_value_q) begin
          cnt_d = TMW8_BOTTOM;
        end else begin
          cnt_d = count_value_q + 8'h01;
        end
        ovf_set = (count_value_q == TMW8_MAX);
        down_d = 1'b0;
      end
      TMW8_WM_FAST: begin
        cnt_d = count_value_q + 8'h01;
        ovf_set = (cnt_d == TMW8_MAX);
        down_d = 1'b0;
      end
      TMW8_WM_PCPWM: begin
        if (!down_q) begin
          if (count_value_q == TMW8_MAX) begin
            down_d = 1'b1;
            cnt_d = count_value_q - 8'h01;
          end else begin
            cnt_d = count_value_q + 8'h01;
          end
        end else begin
          if (count_value_q == TMW8_BOTTOM) begin
            down_d = 1'b0;
            cnt_d = count_value_q + 8'h01;
          end else begin
            cnt_d = count_value_q - 8'h01;
          end
        end
        ovf_set = down_q && (cnt_d == TMW8_BOTTOM) && (count_value_q != TMW8_BOTTOM);
      end
      default: begin
        cnt_d = count_value_q;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_value_q <= TMW8_BOTTOM;
    end else if (wr_cnt) begin
      count_value_q <= i_wdata;
    end else if (tick) begin
      count_value_q <= cnt_d;
    end
  end

  // direction moves only on a tick; a counter write keeps it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      down_q <= 1'b0;
    end else if (tick && !wr_cnt) begin
      down_q <= down_d;
    end
  end

  // counter write hides a match on the next tick
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare value and buffer
  // in pwm modes buffer moves only at a turning point, so no pulse is cut short
  assign load_pc = tick && (wave_mode_select == TMW8_WM_PCPWM) && cnt_at_max;
  assign load_fast = tick && (wave_mode_select == TMW8_WM_FAST) && at_bottom(cnt_d);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_buf_q <= TMW8_CMP_RST;
    end else if (wr_cmp) begin
      cmp_buf_q <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      compare_value_q <= TMW8_CMP_RST;
    end else if (!is_pwm) begin
      // no buffering in non-pwm modes: written value acts at once
      compare_value_q <= wr_cmp ? i_wdata : cmp_buf_q;
    end else if (load_pc) begin
      compare_value_q <= cmp_buf_q;
    end else if (load_fast) begin
      compare_value_q <= cmp_buf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform generator
  always_comb begin
    wave_d = wave_q;
    case (wave_mode_select)
      TMW8_WM_NORMAL, TMW8_WM_CTC: begin
        if (match && output_action_select == TMW8_OA_TOGGLE) begin
          wave_d = !wave_q;
        end else if (match && output_action_select == TMW8_OA_CLEAR) begin
          wave_d = 1'b0;
        end else if (match && output_action_select == TMW8_OA_SET) begin
          wave_d = 1'b1;
        end
      end
      TMW8_WM_FAST: begin
        if (output_action_select == TMW8_OA_TOGGLE) begin
          if (match) begin
            wave_d = !wave_q;
          end
        end else if (output_action_select[1]) begin
          // match at max wins over bottom, giving constant level; zero gives spike
          if (match) begin
            wave_d = output_action_select[0];
          end else if (cnt_at_max) begin
            wave_d = !output_action_select[0];
          end
        end
      end
      TMW8_WM_PCPWM: begin
        if (output_action_select[1]) begin
          if (compare_value_q == TMW8_MAX) begin
            wave_d = !output_action_select[0];
          end else if (compare_value_q == TMW8_BOTTOM) begin
            wave_d = output_action_select[0];
          end else if (match) begin
            wave_d = down_q ? !output_action_select[0] : output_action_select[0];
          end else if (cnt_at_bottom) begin
            // leaving bottom counts up: level must match the down-count result
            wave_d = !output_action_select[0];
          end
        end
      end
      default: begin
        wave_d = wave_q;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_q <= 1'b0;
    end else if (tick && output_action_select != TMW8_OA_NONE) begin
      // action zero freezes the state; it survives mode changes
      wave_q <= wave_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over software clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match_q <= 1'b0;
    end else if (tick) begin
      match_q <= match;
    end else begin
      match_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmpf_q <= 1'b0;
    end else if (match_q) begin
      // match is registered on the tick, so the flag lands one clock later
      cmpf_q <= 1'b1;
    end else if (wr_flg && i_wdata[TMW8_FLG_CMP]) begin
      cmpf_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovf_q <= 1'b0;
    end else if (tick && ovf_set && !wr_cnt) begin
      // a counter write in the same cycle wins over the set
      ovf_q <= 1'b1;
    end else if (wr_flg && i_wdata[TMW8_FLG_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and read port
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= TMW8_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= TMW8_READ_NONE;
    end else if (i_rd) begin
      case (i_addr)
        TMW8_REG_CTRL: rdata_q <= ctrl_q;
        TMW8_REG_COUNT: rdata_q <= count_value_q;
        // compare reads the buffer, the value software last wrote
        TMW8_REG_CMP: rdata_q <= cmp_buf_q;
        TMW8_REG_FLAGS: rdata_q <= {6'h00, cmpf_q, ovf_q};
        default: rdata_q <= TMW8_READ_NONE;
      endcase
    end else begin
      rdata_q <= TMW8_READ_NONE;
    end
  end

  assign o_rdata = rdata_q;
  assign o_wave_output = wave_q;
  assign o_wave_output_oe = ctrl_q[TMW8_CTRL_DIR];
  assign o_overflow_flag = ovf_q;
  assign o_compare_match_flag = cmpf_q;

endmodule

// >>> verification/tb.sv
// testbench: register-port sequences and pin timing for the waveform timer
// assumes tmw8_timer, the pin load model and the bound checker
`timescale 1ns/1ns
module tb;
  import tmw8_pkg::*;
  typedef struct {logic [7:0] ctl; logic [7:0] cv; int sel; int exp;} tmw8_case_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic wave, oe, ovf, cmpf, pin;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  // sel: 0 pin high span, 1 overflow period, 2 compare period, 3 highs in 512
  tmw8_case_t tab[20] = '{
    '{8'h81, 8'h00, 1, 256},
    '{8'h82, 8'h00, 1, 2048},
    '{8'h83, 8'h00, 1, 8192},
    '{8'hB1, 8'h09, 2, 10},
    '{8'hB1, 8'h09, 0, 10},
    '{8'hD9, 8'h3F, 1, 256},
    '{8'hD9, 8'h3F, 0, 64},
    '{8'hF9, 8'h3F, 0, 192},
    '{8'hB9, 8'h20, 0, 256},
    '{8'hD9, 8'h00, 3, 2},
    '{8'hF9, 8'hFF, 3, 512},
    '{8'h59, 8'hFF, 3, 0},
    '{8'hC9, 8'h40, 1, 510},
    '{8'hC9, 8'h40, 0, 128},
    '{8'hE9, 8'h40, 0, 382},
    '{8'hE9, 8'h00, 3, 512},
    '{8'hC9, 8'hFF, 3, 512},
    '{8'hC9, 8'h00, 3, 0},
    '{8'h89, 8'h00, 3, 0},
    '{8'h99, 8'h3F, 1, 256}
  };
  tmw8_timer i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_wave_output(wave), .o_wave_output_oe(oe),
    .o_overflow_flag(ovf), .o_compare_match_flag(cmpf));
  tmw8_pin_load i_load (.i_wave_output(wave), .i_wave_output_oe(oe), .o_pin(pin));
  initial forever #20 clk = ~clk;
  // ceiling well above the slowest prescaled cases
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: cycles %0d expected %0d", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? pin : (s == 1 ? ovf : cmpf);
  endfunction
  // bounded wait, k counts edges until the level shows
  task automatic waitv(input int s, input logic lv, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (pick(s) !== lv && k < 40000);
  endtask
  // flag period: the clearing write costs two edges
  task automatic fper(input int s, output int k);
    wreg(TMW8_REG_FLAGS, 8'h03);
    waitv(s, 1'b1, k);
    wreg(TMW8_REG_FLAGS, 8'h03);
    waitv(s, 1'b1, k);
    k += 2;
  endtask
  task automatic measure(input int s, output int k);
    k = 0;
    if (s == 3) begin
      repeat (512) begin
        @(posedge clk);
        #1;
        if (pin === 1'b1) k++;
      end
    end else if (s == 0) begin
      waitv(0, 1'b0, k);
      waitv(0, 1'b1, k);
      waitv(0, 1'b0, k);
    end else fper(s, k);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rreg(a[3:0], rv);
      cmp8(rv, 8'h00);
    end
    wreg(4'hF, 8'hFF);
    rreg(4'hF, rv);
    cmp8(rv, 8'h00);
    $display("reset values done");
    foreach (tab[i]) begin
      wreg(TMW8_REG_CMP, tab[i].cv);
      wreg(TMW8_REG_CTRL, tab[i].ctl);
      repeat (520) @(posedge clk);
      measure(tab[i].sel, n);
      cmpn(n, tab[i].exp);
      $display("case %0d done", i);
    end
    wreg(TMW8_REG_CTRL, 8'h81);
    wreg(TMW8_REG_COUNT, 8'h10);
    wreg(TMW8_REG_FLAGS, 8'h03);
    wreg(TMW8_REG_COUNT, 8'hF0);
    waitv(1, 1'b1, n);
    cmpn(n, 16);
    $display("count write done");
    wreg(TMW8_REG_CTRL, 8'h91);
    wreg(TMW8_REG_CMP, 8'hF0);
    wreg(TMW8_REG_FLAGS, 8'h03);
    waitv(2, 1'b1, n);
    repeat (100) @(posedge clk);
    wreg(TMW8_REG_CMP, 8'h10);
    wreg(TMW8_REG_FLAGS, 8'h03);
    waitv(2, 1'b1, n);
    wreg(TMW8_REG_CTRL, 8'h00);
    rreg(TMW8_REG_FLAGS, rv);
    cmp8(rv, 8'h03);
    wreg(TMW8_REG_FLAGS, 8'h01);
    rreg(TMW8_REG_FLAGS, rv);
    cmp8(rv, 8'h02);
    $display("missed match and flags done");
    end_of_test();
  end
endmodule

// >>> verification/tmw8_pin_load.sv
// partner: load on the waveform pin with a weak pull-down
// assumes the pin is released whenever the drive enable is low
`timescale 1ns/1ns
module tmw8_pin_load (
  // pin drive from the timer
  input wire logic i_wave_output,
  input wire logic i_wave_output_oe,
  // level seen at the load
  output logic o_pin
);
  // released pin falls to the pull level, never holds the last value
  assign o_pin = i_wave_output_oe ? i_wave_output : 1'b0;
endmodule

// >>> verification/tmw8_props.sv
// checker: port-level properties of the waveform timer
// assumes the plain strobe register port of tmw8_timer
`timescale 1ns/1ns
module tmw8_props
  import tmw8_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pin and flags
  input wire logic o_wave_output,
  input wire logic o_wave_output_oe,
  input wire logic o_overflow_flag,
  input wire logic o_compare_match_flag
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic wc;
  logic wf;
  assign wc = i_wr && i_addr == TMW8_REG_CTRL;
  assign wf = i_wr && i_addr == TMW8_REG_FLAGS;
  ////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_read: assert property (i_rd && i_addr > TMW8_REG_FLAGS |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_oe_write: assert property (wc |=> o_wave_output_oe == $past(i_wdata[7]))
    else $error("pin enable not taken from control write");
  chk_oe_hold: assert property (!wc |=> $stable(o_wave_output_oe))
    else $error("pin enable moved without control write");
  chk_dir_readback: assert property (i_rd && i_addr == TMW8_REG_CTRL |=> o_rdata[7] == $past(o_wave_output_oe))
    else $error("direction bit readback wrong");
  chk_ovf_sticky: assert property (o_overflow_flag && !(wf && i_wdata[TMW8_FLG_OVF]) |=> o_overflow_flag)
    else $error("overflow flag dropped by itself");
  chk_cmp_sticky: assert property (o_compare_match_flag && !(wf && i_wdata[TMW8_FLG_CMP]) |=> o_compare_match_flag)
    else $error("compare flag dropped by itself");
  chk_flag_read: assert property (i_rd && i_addr == TMW8_REG_FLAGS
    |=> o_rdata[1:0] == $past({o_compare_match_flag, o_overflow_flag}))
    else $error("flag readback wrong");
  cover property (wf ##1 !o_overflow_flag);
  cover property ($rose(o_wave_output) && o_wave_output_oe);
  cover property ($rose(o_compare_match_flag));
endmodule
bind tmw8_timer tmw8_props i_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wave_output(o_wave_output),
  .o_wave_output_oe(o_wave_output_oe), .o_overflow_flag(o_overflow_flag),
  .o_compare_match_flag(o_compare_match_flag));
